// ===== logic/dosd_pkg.sv
package dosd_pkg;
    // clock and tick timing
    localparam int unsigned CLK_FREQ_MHZ     = 100;
    localparam int unsigned TICK_PERIOD_US   = 10000;
    localparam int unsigned TICK_CYCLES      = TICK_PERIOD_US * CLK_FREQ_MHZ;
    localparam int unsigned RESP_TIME_MS     = 100;
    localparam int unsigned ZC_HOLD_MS       = 100;
    localparam int unsigned TICK_MS          = TICK_PERIOD_US / 1000;
    localparam logic [15:0] RESP_TICKS       = 16'(RESP_TIME_MS / TICK_MS);
    localparam logic [15:0] ZC_HOLD_TICKS    = 16'(ZC_HOLD_MS / TICK_MS);
    localparam int          TMR_W            = 16;

    // register byte offsets
    localparam logic [7:0] OFS_FREQ_LVL      = 8'h00;
    localparam logic [7:0] OFS_REV_LVL       = 8'h04;
    localparam logic [7:0] OFS_OC_LVL        = 8'h08;
    localparam logic [7:0] OFS_OC_DELAY      = 8'h0c;
    localparam logic [7:0] OFS_ZC_LVL        = 8'h10;
    localparam logic [7:0] OFS_ZC_TIME       = 8'h14;
    localparam logic [7:0] OFS_OC_RET        = 8'h18;
    localparam logic [7:0] OFS_OC_TRIP       = 8'h1c;
    localparam logic [7:0] OFS_RMT_SEL       = 8'h20;
    localparam logic [7:0] OFS_RMT_DATA      = 8'h24;
    localparam logic [7:0] OFS_TERM_A        = 8'h28;
    localparam logic [7:0] OFS_TERM_B        = 8'h2c;
    localparam logic [7:0] OFS_TERM_C        = 8'h30;
    localparam logic [7:0] OFS_STATUS        = 8'h34;

    // reset values (frequency 0.1 Hz, current %, time 0.01 s)
    localparam logic [15:0] RST_FREQ_LVL     = 16'h003c;
    localparam logic [15:0] SENTINEL         = 16'h270f;
    localparam logic [15:0] RST_OC_LVL       = 16'h0096;
    localparam logic [15:0] RST_OC_DELAY     = 16'h0000;
    localparam logic [15:0] RST_ZC_LVL       = 16'h0005;
    localparam logic [15:0] RST_ZC_TIME      = 16'h0032;
    localparam logic [15:0] RST_OC_RET       = 16'h000a;
    localparam logic [7:0]  RST_TERM         = 8'h00;
    localparam logic [11:0] RMT_MASK_ZERO    = 12'h000;

    // selection codes
    localparam logic [7:0] FN_FREQ           = 8'h04;
    localparam logic [7:0] FN_OC             = 8'h0c;
    localparam logic [7:0] FN_ZC             = 8'h0d;
    localparam logic [7:0] FN_RMT            = 8'h60;
    localparam logic [7:0] FN_NEG_OFS        = 8'h64;
    localparam logic [7:0] RMT_CLR           = 8'h00;
    localparam logic [7:0] RMT_KEEP_PWR      = 8'h01;
    localparam logic [7:0] RMT_CLR_HOLD      = 8'h0a;
    localparam logic [7:0] RMT_KEEP_HOLD     = 8'h0b;

    localparam int NUM_TERM                  = 3;
    localparam int RMT_W                     = 12;
    localparam int RMT_BIT_A                 = 0;
    localparam int RMT_BIT_B                 = 1;
    localparam int RMT_BIT_C                 = 2;
endpackage : dosd_pkg

// ===== logic/dosd_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dosd_tmr_if;
    logic                       run;
    logic [dosd_pkg::TMR_W-1:0] limit;
    logic                       done;
    modport ctl (output run, output limit, input done);
    modport tmr (input run, input limit, output done);
endinterface : dosd_tmr_if
`default_nettype wire

// ===== logic/dosd_timer.sv
`timescale 1ns/1ps
`default_nettype none
// tick counter: restarts when run drops, done once limit ticks have passed
module dosd_timer (
    input  wire logic  mclk_i,
    input  wire logic  rst_n_i,
    input  wire logic  clk_en_i,
    input  wire logic  tick_i,
    dosd_tmr_if.tmr    t
);
    logic [dosd_pkg::TMR_W-1:0] cnt_ff;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else if (clk_en_i) begin
            if (!t.run) begin
                cnt_ff <= '0;
            end else if (tick_i && cnt_ff < t.limit) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    assign t.done = t.run && (cnt_ff >= t.limit);

    a_timer_restart: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && !t.run) |=> (cnt_ff == '0))
        else $error("timer did not restart");
endmodule : dosd_timer
`default_nettype wire

// ===== logic/dosd_top.sv
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dosd_top #(
    parameter int unsigned TICK_CYCLES = dosd_pkg::TICK_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [15:0] out_freq_i,
    input  wire logic        reverse_i,
    input  wire logic        dc_brake_i,
    input  wire logic        running_i,
    input  wire logic        start_i,
    input  wire logic [7:0]  out_current_i,
    input  wire logic        inv_reset_i,
    input  wire logic        power_fail_i,
    input  wire logic        nv_load_i,
    input  wire logic [7:0]  nv_sel_i,
    input  wire logic [11:0] nv_data_i,
    output logic             nv_save_o,
    output logic [11:0]      nv_data_o,
    output logic [2:0]       term_o,
    output logic             freq_detect_out_o,
    output logic             overcurrent_detect_out_o,
    output logic             zero_current_out_o,
    output logic             current_detect_fault_o
);
    logic [15:0] freq_lvl_ff;
    logic [15:0] rev_lvl_ff;
    logic [15:0] oc_lvl_ff;
    logic [15:0] oc_delay_ff;
    logic [15:0] zc_lvl_ff;
    logic [15:0] zc_time_ff;
    logic [15:0] oc_ret_ff;
    logic        oc_trip_ff;
    logic [7:0]  rmt_sel_ff;
    logic [11:0] rmt_data_ff;
    logic [7:0]  term_sel_ff [dosd_pkg::NUM_TERM];
    logic        ack_ff;
    logic [31:0] prdata_ff;
    logic        freq_det_ff;
    logic        oc_out_ff;
    logic        zc_out_ff;
    logic        fault_ff;
    logic        trip_arm_ff;
    logic [2:0]  term_ff;
    logic        nv_save_ff;
    logic [11:0] nv_data_ff;
    logic [31:0] tick_cnt_ff;
    logic        tick;
    logic        wr_en;
    logic        access_first;
    logic        addr_hit;
    logic [31:0] rd_mux;
    logic [15:0] freq_thr;
    logic        oc_cond;
    logic        zc_cond;
    logic        rmt_keep_pwr;
    logic        rmt_keep_rst;
    logic        oc_latch;
    logic        nxt_oc_out;
    logic        nxt_zc_out;
    logic [2:0]  nxt_term;

    dosd_tmr_if oc_dly_if ();
    dosd_tmr_if oc_hld_if ();
    dosd_tmr_if zc_dly_if ();
    dosd_tmr_if zc_hld_if ();

    // periodic tick
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tick_cnt_ff <= '0;
        end else if (clk_en_i) begin
            tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 32'h1;
        end
    end
    assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

    // apb slave: two-cycle access phase
    assign access_first = psel_i && penable_i && !ack_ff;
    assign wr_en        = psel_i && penable_i && ack_ff && pwrite_i && addr_hit;
    assign pready_o     = ack_ff;
    assign pslverr_o    = ack_ff && !addr_hit;
    assign prdata_o     = prdata_ff;
    assign addr_hit     = (paddr_i[1:0] == 2'h0) && (paddr_i <= dosd_pkg::OFS_STATUS);

    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr_i)
            dosd_pkg::OFS_FREQ_LVL: rd_mux = {16'h0, freq_lvl_ff};
            dosd_pkg::OFS_REV_LVL:  rd_mux = {16'h0, rev_lvl_ff};
            dosd_pkg::OFS_OC_LVL:   rd_mux = {16'h0, oc_lvl_ff};
            dosd_pkg::OFS_OC_DELAY: rd_mux = {16'h0, oc_delay_ff};
            dosd_pkg::OFS_ZC_LVL:   rd_mux = {16'h0, zc_lvl_ff};
            dosd_pkg::OFS_ZC_TIME:  rd_mux = {16'h0, zc_time_ff};
            dosd_pkg::OFS_OC_RET:   rd_mux = {16'h0, oc_ret_ff};
            dosd_pkg::OFS_OC_TRIP:  rd_mux = {31'h0, oc_trip_ff};
            dosd_pkg::OFS_RMT_SEL:  rd_mux = {24'h0, rmt_sel_ff};
            dosd_pkg::OFS_RMT_DATA: rd_mux = {20'h0, rmt_data_ff};
            dosd_pkg::OFS_TERM_A:   rd_mux = {24'h0, term_sel_ff[0]};
            dosd_pkg::OFS_TERM_B:   rd_mux = {24'h0, term_sel_ff[1]};
            dosd_pkg::OFS_TERM_C:   rd_mux = {24'h0, term_sel_ff[2]};
            dosd_pkg::OFS_STATUS:   rd_mux = {25'h0, term_ff, fault_ff, zc_out_ff, oc_out_ff, freq_det_ff};
            default:                rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ack_ff    <= 1'b0;
            prdata_ff <= 32'h0;
        end else if (clk_en_i) begin
            ack_ff <= access_first;
            if (access_first) begin
                prdata_ff <= pwrite_i ? 32'h0 : rd_mux;
            end
        end
    end

    // settings registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            freq_lvl_ff <= dosd_pkg::RST_FREQ_LVL;
            rev_lvl_ff  <= dosd_pkg::SENTINEL;
            oc_lvl_ff   <= dosd_pkg::RST_OC_LVL;
            oc_delay_ff <= dosd_pkg::RST_OC_DELAY;
            zc_lvl_ff   <= dosd_pkg::RST_ZC_LVL;
            zc_time_ff  <= dosd_pkg::RST_ZC_TIME;
            oc_ret_ff   <= dosd_pkg::RST_OC_RET;
            oc_trip_ff  <= 1'b0;
            for (int i = 0; i < dosd_pkg::NUM_TERM; i++) begin
                term_sel_ff[i] <= dosd_pkg::RST_TERM;
            end
        end else if (clk_en_i && wr_en) begin
            unique case (paddr_i)
                dosd_pkg::OFS_FREQ_LVL: freq_lvl_ff    <= pwdata_i[15:0];
                dosd_pkg::OFS_REV_LVL:  rev_lvl_ff     <= pwdata_i[15:0];
                dosd_pkg::OFS_OC_LVL:   oc_lvl_ff      <= pwdata_i[15:0];
                dosd_pkg::OFS_OC_DELAY: oc_delay_ff    <= pwdata_i[15:0];
                dosd_pkg::OFS_ZC_LVL:   zc_lvl_ff      <= pwdata_i[15:0];
                dosd_pkg::OFS_ZC_TIME:  zc_time_ff     <= pwdata_i[15:0];
                dosd_pkg::OFS_OC_RET:   oc_ret_ff      <= pwdata_i[15:0];
                dosd_pkg::OFS_OC_TRIP:  oc_trip_ff     <= pwdata_i[0];
                dosd_pkg::OFS_TERM_A:   term_sel_ff[0] <= pwdata_i[7:0];
                dosd_pkg::OFS_TERM_B:   term_sel_ff[1] <= pwdata_i[7:0];
                dosd_pkg::OFS_TERM_C:   term_sel_ff[2] <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // remote output word and its retention
    assign rmt_keep_pwr = (rmt_sel_ff == dosd_pkg::RMT_KEEP_PWR) || (rmt_sel_ff == dosd_pkg::RMT_KEEP_HOLD);
    assign rmt_keep_rst = (rmt_sel_ff == dosd_pkg::RMT_CLR_HOLD) || (rmt_sel_ff == dosd_pkg::RMT_KEEP_HOLD);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rmt_sel_ff  <= dosd_pkg::RMT_CLR;
            rmt_data_ff <= dosd_pkg::RMT_MASK_ZERO;
            nv_save_ff  <= 1'b0;
            nv_data_ff  <= dosd_pkg::RMT_MASK_ZERO;
        end else if (clk_en_i) begin
            nv_save_ff <= power_fail_i && rmt_keep_pwr;
            if (power_fail_i) begin
                nv_data_ff <= rmt_data_ff;
                if (!rmt_keep_pwr) begin
                    rmt_data_ff <= dosd_pkg::RMT_MASK_ZERO;
                end
            end else if (nv_load_i) begin
                rmt_sel_ff <= nv_sel_i;
                if ((nv_sel_i == dosd_pkg::RMT_KEEP_PWR) || (nv_sel_i == dosd_pkg::RMT_KEEP_HOLD)) begin
                    rmt_data_ff <= nv_data_i;
                end
            end else if (inv_reset_i) begin
                if (!rmt_keep_rst) begin
                    rmt_data_ff <= dosd_pkg::RMT_MASK_ZERO;
                end
            end else if (wr_en && paddr_i == dosd_pkg::OFS_RMT_SEL) begin
                rmt_sel_ff <= pwdata_i[7:0];
            end else if (wr_en && paddr_i == dosd_pkg::OFS_RMT_DATA) begin
                rmt_data_ff <= pwdata_i[11:0];
            end
        end
    end
    assign nv_save_o = nv_save_ff;
    assign nv_data_o = nv_data_ff;

    // frequency detection
    assign freq_thr = (reverse_i && rev_lvl_ff != dosd_pkg::SENTINEL) ? rev_lvl_ff : freq_lvl_ff;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            freq_det_ff <= 1'b0;
        end else if (clk_en_i) begin
            freq_det_ff <= !dc_brake_i && (out_freq_i >= freq_thr);
        end
    end

    // overcurrent detection
    assign oc_cond          = running_i && ({8'h0, out_current_i} > oc_lvl_ff);
    assign oc_dly_if.run    = oc_cond;
    assign oc_dly_if.limit  = oc_delay_ff + dosd_pkg::RESP_TICKS;
    assign oc_hld_if.run    = oc_out_ff;
    assign oc_hld_if.limit  = oc_ret_ff;
    assign oc_latch         = (oc_ret_ff == dosd_pkg::SENTINEL);

    always_comb begin
        nxt_oc_out = oc_out_ff;
        if (!oc_out_ff) begin
            nxt_oc_out = oc_dly_if.done;
        end else if (oc_latch) begin
            if (inv_reset_i || (start_i && !fault_ff)) begin
                nxt_oc_out = 1'b0;
            end
        end else if (oc_hld_if.done && !oc_dly_if.done) begin
            nxt_oc_out = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            oc_out_ff   <= 1'b0;
            trip_arm_ff <= 1'b0;
            fault_ff    <= 1'b0;
        end else if (clk_en_i) begin
            oc_out_ff <= nxt_oc_out;
            if (!oc_out_ff) begin
                trip_arm_ff <= oc_trip_ff;
            end
            if (!oc_out_ff && nxt_oc_out && trip_arm_ff) begin
                fault_ff <= 1'b1;
            end else if (inv_reset_i) begin
                fault_ff <= 1'b0;
            end
        end
    end

    // zero-current detection
    assign zc_cond         = running_i && (zc_lvl_ff != 16'h0) && ({8'h0, out_current_i} < zc_lvl_ff);
    assign zc_dly_if.run   = zc_cond;
    assign zc_dly_if.limit = zc_time_ff + dosd_pkg::RESP_TICKS;
    assign zc_hld_if.run   = zc_out_ff;
    assign zc_hld_if.limit = dosd_pkg::ZC_HOLD_TICKS;

    always_comb begin
        nxt_zc_out = zc_out_ff;
        if (!zc_out_ff) begin
            nxt_zc_out = zc_dly_if.done;
        end else if (zc_hld_if.done && !zc_dly_if.done) begin
            nxt_zc_out = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            zc_out_ff <= 1'b0;
        end else if (clk_en_i) begin
            zc_out_ff <= nxt_zc_out;
        end
    end

    dosd_timer u_oc_dly (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .tick_i(tick), .t(oc_dly_if.tmr));
    dosd_timer u_oc_hld (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .tick_i(tick), .t(oc_hld_if.tmr));
    dosd_timer u_zc_dly (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .tick_i(tick), .t(zc_dly_if.tmr));
    dosd_timer u_zc_hld (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .tick_i(tick), .t(zc_hld_if.tmr));

    // output terminal mapping
    localparam int RMT_IDX [dosd_pkg::NUM_TERM] = '{dosd_pkg::RMT_BIT_A, dosd_pkg::RMT_BIT_B, dosd_pkg::RMT_BIT_C};
    always_comb begin
        for (int i = 0; i < dosd_pkg::NUM_TERM; i++) begin
            unique case (term_sel_ff[i])
                dosd_pkg::FN_FREQ:                       nxt_term[i] = freq_det_ff;
                dosd_pkg::FN_FREQ + dosd_pkg::FN_NEG_OFS: nxt_term[i] = !freq_det_ff;
                dosd_pkg::FN_OC:                         nxt_term[i] = oc_out_ff;
                dosd_pkg::FN_OC + dosd_pkg::FN_NEG_OFS:   nxt_term[i] = !oc_out_ff;
                dosd_pkg::FN_ZC:                         nxt_term[i] = zc_out_ff;
                dosd_pkg::FN_ZC + dosd_pkg::FN_NEG_OFS:   nxt_term[i] = !zc_out_ff;
                dosd_pkg::FN_RMT:                        nxt_term[i] = rmt_data_ff[RMT_IDX[i]];
                dosd_pkg::FN_RMT + dosd_pkg::FN_NEG_OFS:  nxt_term[i] = !rmt_data_ff[RMT_IDX[i]];
                default:                                 nxt_term[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            term_ff <= 3'h0;
        end else if (clk_en_i) begin
            term_ff <= nxt_term;
        end
    end

    assign term_o                   = term_ff;
    assign freq_detect_out_o        = freq_det_ff;
    assign overcurrent_detect_out_o = oc_out_ff;
    assign zero_current_out_o       = zc_out_ff;
    assign current_detect_fault_o   = fault_ff;

    // checks
    sequence s_oc_rise;
        clk_en_i && !oc_out_ff && nxt_oc_out;
    endsequence

    a_freq_brake_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && dc_brake_i) |=> !freq_det_ff)
        else $error("frequency detect on during braking");
    a_freq_reverse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && !dc_brake_i && reverse_i && rev_lvl_ff != dosd_pkg::SENTINEL && out_freq_i >= rev_lvl_ff)
        |=> freq_det_ff)
        else $error("reverse threshold not applied");
    a_trip_on_rise: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (s_oc_rise and trip_arm_ff) |=> (fault_ff && oc_out_ff))
        else $error("missing trip on overcurrent");
    a_trip_cause: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(fault_ff) |-> (oc_out_ff && !$past(oc_out_ff) && $past(trip_arm_ff)))
        else $error("trip without fresh overcurrent");
    a_oc_latched: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && oc_out_ff && oc_latch && !start_i && !inv_reset_i) |=> oc_out_ff)
        else $error("latched overcurrent released");
    a_zc_disabled: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && !zc_out_ff && zc_lvl_ff == 16'h0) |=> !zc_out_ff)
        else $error("zero current asserted while disabled");
    a_zc_min_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && zc_out_ff && u_zc_hld.cnt_ff < dosd_pkg::ZC_HOLD_TICKS) |=> zc_out_ff)
        else $error("zero current dropped too soon");
    a_rmt_pf_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && power_fail_i && !rmt_keep_pwr) |=> (rmt_data_ff == dosd_pkg::RMT_MASK_ZERO))
        else $error("remote word kept on power failure");
    a_rmt_rst_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && inv_reset_i && rmt_keep_rst && !power_fail_i && !nv_load_i) |=> $stable(rmt_data_ff))
        else $error("remote word changed on inverter reset");
    a_term_freq: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && term_sel_ff[1] == dosd_pkg::FN_FREQ + dosd_pkg::FN_NEG_OFS) |=> (term_ff[1] == !$past(freq_det_ff)))
        else $error("inverted frequency terminal wrong");
endmodule : dosd_top
`default_nettype wire

// ===== tb/dosd_brake_model.sv
`timescale 1ns/1ps
`default_nettype none
// external brake: coil closes one cycle after terminal c conducts
module dosd_brake_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] term_i,
    output logic            brake_closed_o
);
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) brake_closed_o <= 1'b0;
        else brake_closed_o <= term_i[2];
    end
endmodule : dosd_brake_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk = '0, rst_n = '0, psel = '0, pen = '0, pwr = '0, rev = '0, dcb = '0, run = '0, ce = '1;
    logic        start = '0, invr = '0, pf = '0, nvl = '0, pready, sv, pslverr, nvs, fd, oc, zc, flt, brake;
    logic [7:0]  paddr = '0, cur = '0, nvsel = '0;
    logic [31:0] pwdata = '0, prdata, rd_v;
    logic [15:0] freq = '0;
    logic [11:0] nvd = '0, nvdo;
    logic [2:0]  term;
    logic [3:0]  st;
    int          err_count = 0, total_checks = 0, n;
    assign st = {flt, zc, oc, fd};
    always #5 mclk = ~mclk;
    dosd_top #(.TICK_CYCLES(10)) i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .clk_en_i(ce), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .out_freq_i(freq), .reverse_i(rev), .dc_brake_i(dcb),
        .running_i(run), .start_i(start), .out_current_i(cur), .inv_reset_i(invr), .power_fail_i(pf),
        .nv_load_i(nvl), .nv_sel_i(nvsel), .nv_data_i(nvd), .nv_save_o(nvs), .nv_data_o(nvdo), .term_o(term),
        .freq_detect_out_o(fd), .overcurrent_detect_out_o(oc), .zero_current_out_o(zc),
        .current_detect_fault_o(flt));
    dosd_brake_model i_brake (.mclk_i(mclk), .rst_n_i(rst_n), .term_i(term), .brake_closed_o(brake));
    task automatic end_of_test;
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        pen <= 1'b1;
        for (int i = 0; i <= 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
            if (i == 20) begin
                err_count++;
                end_of_test();
            end
        end
        rd_v = prdata;
        sv = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wait_bit(input int b);
        n = 0;
        while (st[b] !== 1'b1) begin
            @(posedge mclk);
            n++;
            if (n > 2000) begin
                err_count++;
                end_of_test();
            end
        end
    endtask : wait_bit
    task automatic ireset;
        invr <= 1'b1;
        @(posedge mclk);
        invr <= 1'b0;
        cyc(3);
    endtask : ireset
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        apb(1'b0, dosd_pkg::OFS_REV_LVL, '0);
        chk(rd_v[15:0], dosd_pkg::SENTINEL);
        apb(1'b0, 8'h38, '0);
        chk({sv, rd_v[14:0]}, 16'h8000);
        apb(1'b1, dosd_pkg::OFS_TERM_A, 16'(dosd_pkg::FN_FREQ));
        apb(1'b1, dosd_pkg::OFS_TERM_B, 16'(dosd_pkg::FN_FREQ + dosd_pkg::FN_NEG_OFS));
        freq <= dosd_pkg::RST_FREQ_LVL;
        cyc(3);
        chk(16'({fd, term[1:0]}), 16'h0005);
        freq <= dosd_pkg::RST_FREQ_LVL - 16'h0001;
        cyc(3);
        chk(16'(fd), 16'h0000);
        apb(1'b1, dosd_pkg::OFS_REV_LVL, 16'h0064);
        freq <= 16'h0063;
        rev <= 1'b1;
        cyc(3);
        chk(16'(fd), 16'h0000);
        rev <= 1'b0;
        dcb <= 1'b1;
        cyc(3);
        chk(16'(fd), 16'h0000);
        dcb <= 1'b0;
        apb(1'b1, dosd_pkg::OFS_OC_TRIP, 16'h0001);
        apb(1'b1, dosd_pkg::OFS_TERM_C, 16'(dosd_pkg::FN_OC));
        apb(1'b1, dosd_pkg::OFS_TERM_B, 16'(dosd_pkg::FN_OC + dosd_pkg::FN_NEG_OFS));
        run <= 1'b1;
        cur <= 8'hc8;
        wait_bit(1);
        chk(16'(n >= 90 && n <= 115), 16'h0001);
        chk(16'(flt), 16'h0001);
        cur <= 8'h64;
        cyc(50);
        chk(16'({oc, term[2:1]}), 16'h0006);
        cyc(150);
        chk(16'({oc, term[1]}), 16'h0001);
        ireset();
        apb(1'b1, dosd_pkg::OFS_OC_TRIP, 16'h0000);
        apb(1'b1, dosd_pkg::OFS_OC_RET, dosd_pkg::SENTINEL);
        cur <= 8'hc8;
        wait_bit(1);
        cur <= 8'h00;
        cyc(300);
        chk(16'({oc, flt}), 16'h0002);
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        cyc(3);
        chk(16'(oc), 16'h0000);
        apb(1'b1, dosd_pkg::OFS_ZC_LVL, 16'h0000);
        cyc(800);
        chk(16'(zc), 16'h0000);
        apb(1'b1, dosd_pkg::OFS_TERM_C, 16'(dosd_pkg::FN_ZC));
        apb(1'b1, dosd_pkg::OFS_TERM_B, 16'(dosd_pkg::FN_ZC + dosd_pkg::FN_NEG_OFS));
        apb(1'b1, dosd_pkg::OFS_ZC_LVL, dosd_pkg::RST_ZC_LVL);
        wait_bit(2);
        chk(16'(n >= 570 && n <= 620), 16'h0001);
        cur <= 8'h32;
        cyc(50);
        chk(16'({zc, brake, term[1]}), 16'h0006);
        apb(1'b1, dosd_pkg::OFS_TERM_A, 16'(dosd_pkg::FN_RMT));
        apb(1'b1, dosd_pkg::OFS_TERM_B, 16'(dosd_pkg::FN_RMT + dosd_pkg::FN_NEG_OFS));
        apb(1'b1, dosd_pkg::OFS_RMT_DATA, 16'h0001);
        cyc(3);
        chk(16'(term[1:0]), 16'h0003);
        apb(1'b1, dosd_pkg::OFS_RMT_DATA, 16'h0002);
        cyc(3);
        chk(16'(term[1:0]), 16'h0000);
        apb(1'b1, dosd_pkg::OFS_RMT_SEL, 16'(dosd_pkg::RMT_CLR_HOLD));
        ireset();
        chk(16'(term[1:0]), 16'h0000);
        apb(1'b1, dosd_pkg::OFS_RMT_SEL, 16'(dosd_pkg::RMT_KEEP_PWR));
        apb(1'b1, dosd_pkg::OFS_RMT_DATA, 16'h05a5);
        pf <= 1'b1;
        @(posedge mclk);
        pf <= 1'b0;
        @(posedge mclk);
        chk(16'({nvs, nvdo}), 16'h15a5);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        apb(1'b0, dosd_pkg::OFS_RMT_DATA, '0);
        chk(rd_v[15:0], 16'h0000);
        nvl <= 1'b1;
        nvsel <= dosd_pkg::RMT_KEEP_HOLD;
        nvd <= 12'h5a5;
        @(posedge mclk);
        nvl <= 1'b0;
        apb(1'b0, dosd_pkg::OFS_RMT_DATA, '0);
        chk(rd_v[15:0], 16'h05a5);
        ce <= 1'b0;
        freq <= 16'h0000;
        cyc(3);
        chk(16'(fd), 16'h0001);
        ce <= 1'b1;
        cyc(3);
        chk(16'(fd), 16'h0000);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
